// [hw/pmfe_global_status_control_regs_ctrl.sv]
// global feature and event counter control registers
`timescale 1ns/1ns
`include "pmfe_defines.svh"
module pmfe_glb_ctrl #(
	parameter int NUM_DEV_PORTS = `PMFE_DEV_PORTS,
	parameter logic [4:0] FEAT_SUPPORTED = 5'h1f
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register commands from the host port
	input wire logic reg_req,
	input wire pmfe_pkg::pmfe_req_s reg_cmd,
	output logic reg_ack,
	output logic [31:0] reg_rdata,
	// event counter control
	output logic cnt_enable,
	output logic [`PMFE_CLR_CHANNELS-1:0] cnt_clear,
	input wire logic [`PMFE_CLR_CHANNELS-1:0] cnt_clear_done,
	// error summary
	input wire logic [NUM_DEV_PORTS-1:0][31:0] port_error_register,
	input wire logic [31:0] err_bit_enable,
	output logic [`PMFE_DEV_PORTS-1:0] err_summary,
	// feature side effects
	input wire logic bist_fis_in,
	output logic bist_accept,
	input wire logic ports_all_idle,
	output logic pmreq_ok,
	output logic ssc_enable,
	output logic async_notify
);

	//------------------------------------------------------------------
	// constants
	//------------------------------------------------------------------
	localparam int NCH = `PMFE_CLR_CHANNELS;
	localparam int NFE = `PMFE_FEN_WIDTH;
	localparam logic [NCH-2:0] DEV_MASK =
		(NCH-1)'((32'h1 << NUM_DEV_PORTS) - 32'h1);
	localparam logic [NCH-1:0] CLR_MASK = {1'b1, DEV_MASK};
	localparam logic EVCNT_SUP = FEAT_SUPPORTED[`PMFE_FEAT_EVCNT];
	localparam logic [NFE-1:0] FEN_SUP = FEAT_SUPPORTED[NFE-1:0];
	localparam logic [NFE-1:0] FEN_RESET = FEN_SUP & `PMFE_FEN_RESET_MASK;

	//------------------------------------------------------------------
	// decode
	//------------------------------------------------------------------
	logic hit_evctl, hit_fsup, hit_fen, wr_evctl, wr_fen;
	logic [NCH-1:0] clr_start, clr_busy, clr_pulse;

	// register number decode
	always_comb begin
		hit_evctl = reg_req && (reg_cmd.num == `PMFE_REG_EVCTL);
		hit_fsup = reg_req && (reg_cmd.num == `PMFE_REG_FSUP);
		hit_fen = reg_req && (reg_cmd.num == `PMFE_REG_FEN);
		wr_evctl = hit_evctl && reg_cmd.wr && EVCNT_SUP; // R1
		wr_fen = hit_fen && reg_cmd.wr;
		// ones start clears, zeros do nothing, any enable state
		clr_start = wr_evctl ? // R7 R8 R9 R21
			(reg_cmd.wdata[`PMFE_EVCTL_CLR_MSB:`PMFE_EVCTL_CLR_LSB]
			& CLR_MASK) : '0;
	end

	//------------------------------------------------------------------
	// counter clear sequencer
	//------------------------------------------------------------------
	pmfe_cnt_clr #(
		.NCH(NCH)
	) u_clr (
		.core_clk(core_clk),
		.rst(rst),
		.start(clr_start),
		.done(cnt_clear_done),
		.clr_pulse(clr_pulse),
		.busy(clr_busy)
	);
	assign cnt_clear = clr_pulse; // R7 R8

	//------------------------------------------------------------------
	// control and enable registers
	//------------------------------------------------------------------
	logic en_reg, en_next;
	logic [NFE-1:0] fen_reg, fen_next;

	// enable bit only follows a write; no reset from link events
	always_comb begin
		en_next = en_reg; // R3 R4
		if (wr_evctl) begin
			en_next = reg_cmd.wdata[`PMFE_EVCTL_EN_BIT]; // R2 R5
		end
		fen_next = fen_reg;
		if (wr_fen) begin
			fen_next = reg_cmd.wdata[NFE-1:0] & FEN_SUP; // R16
		end
	end

	// power-up values
	always_ff @(posedge core_clk) begin
		if (rst) begin
			en_reg <= 1'b0; // R4
			fen_reg <= FEN_RESET; // R18 R19
		end else begin
			en_reg <= en_next;
			fen_reg <= fen_next;
		end
	end
	assign cnt_enable = en_reg; // R3

	//------------------------------------------------------------------
	// read path
	//------------------------------------------------------------------
	logic ack_reg, ack_next;
	logic [31:0] rdata_reg, rdata_next;

	// unmapped and reserved numbers return zero
	always_comb begin
		ack_next = reg_req;
		rdata_next = 32'h0000_0000; // R10
		if (hit_evctl && EVCNT_SUP) begin
			rdata_next[`PMFE_EVCTL_CLR_MSB:`PMFE_EVCTL_CLR_LSB] =
				clr_busy; // R6 R9
			rdata_next[`PMFE_EVCTL_EN_BIT] = en_reg;
		end else if (hit_fsup) begin
			rdata_next[4:0] = FEAT_SUPPORTED; // R11 R12
		end else if (hit_fen) begin
			rdata_next[NFE-1:0] = fen_reg; // R17
		end
	end

	// read answer registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ack_reg <= 1'b0;
			rdata_reg <= `PMFE_EVCTL_RESET;
		end else begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
		end
	end
	assign reg_ack = ack_reg;
	assign reg_rdata = rdata_reg;

	//------------------------------------------------------------------
	// error summary and feature outputs
	//------------------------------------------------------------------
	logic [`PMFE_DEV_PORTS-1:0] sum_now, sum_reg;
	logic bist_reg, bist_next, pmreq_reg, pmreq_next;
	logic ssc_reg, ssc_next, notify_reg, notify_next;

	// masked OR per port, zero where no port exists
	genvar p;
	generate
		for (p = 0; p < `PMFE_DEV_PORTS; p++) begin : g_sum
			if (p < NUM_DEV_PORTS) begin : g_on
				assign sum_now[p] =
					|(port_error_register[p] & err_bit_enable); // R20
			end else begin : g_off
				assign sum_now[p] = 1'b0; // R20
			end
		end
	endgenerate

	// feature gating from enables
	always_comb begin
		bist_next = bist_fis_in && fen_reg[`PMFE_FEAT_BIST]; // R13
		pmreq_next = fen_reg[`PMFE_FEAT_PMREQ]
			&& ports_all_idle; // R14 R18
		ssc_next = fen_reg[`PMFE_FEAT_SSC];
		notify_next = fen_reg[`PMFE_FEAT_ASYNC]
			&& |(sum_now & ~sum_reg); // R15
	end

	// output registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sum_reg <= '0;
			bist_reg <= 1'b0;
			pmreq_reg <= 1'b0;
			ssc_reg <= 1'b0;
			notify_reg <= 1'b0;
		end else begin
			sum_reg <= sum_now;
			bist_reg <= bist_next;
			pmreq_reg <= pmreq_next;
			ssc_reg <= ssc_next;
			notify_reg <= notify_next;
		end
	end
	assign err_summary = sum_reg;
	assign bist_accept = bist_reg;
	assign pmreq_ok = pmreq_reg;
	assign ssc_enable = ssc_reg;
	assign async_notify = notify_reg;

	//------------------------------------------------------------------
	// assertions
	//------------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	sequence s_rd(logic [15:0] n);
		reg_req && !reg_cmd.wr && reg_cmd.num == n;
	endsequence

	sequence s_evctl_wr;
		reg_req && reg_cmd.wr && reg_cmd.num == `PMFE_REG_EVCTL;
	endsequence

	property p_evctl_lo_zero;
		s_rd(`PMFE_REG_EVCTL) ##1 reg_ack |-> reg_rdata[15:1] == 15'h0000;
	endproperty
	a_evctl_lo_zero: assert property (p_evctl_lo_zero) // R6
		else $error("control reserved bits not zero");

	property p_en_follows_wr;
		s_evctl_wr ##1 1'b1 |->
			cnt_enable == (EVCNT_SUP && $past(reg_cmd.wdata[0]));
	endproperty
	a_en_follows_wr: assert property (p_en_follows_wr) // R2
		else $error("enable bit did not follow write");

	property p_en_hold;
		!(reg_req && reg_cmd.wr && reg_cmd.num == `PMFE_REG_EVCTL)
			|=> $stable(cnt_enable);
	endproperty
	a_en_hold: assert property (p_en_hold) // R4
		else $error("enable changed without a write");

	property p_clear_cause;
		cnt_clear != 16'h0000 |->
			$past(wr_evctl && (reg_cmd.wdata[31:16] != 16'h0000));
	endproperty
	a_clear_cause: assert property (p_clear_cause) // R5
		else $error("counter clear without a reset bit write");

	property p_host_clear;
		wr_evctl && reg_cmd.wdata[31] && !clr_busy[15]
			|=> cnt_clear[15] ##1 !cnt_clear[15];
	endproperty
	a_host_clear: assert property (p_host_clear) // R8
		else $error("host port clear not issued as one pulse");

	property p_port0_clear;
		wr_evctl && reg_cmd.wdata[16] && !clr_busy[0] |=> cnt_clear[0];
	endproperty
	a_port0_clear: assert property (p_port0_clear) // R7
		else $error("port 0 clear not issued");

	property p_self_clear;
		clr_busy[15] && cnt_clear_done[15] && !clr_start[15]
			|=> !clr_busy[15];
	endproperty
	a_self_clear: assert property (p_self_clear) // R9
		else $error("host reset bit did not self clear");

	property p_reserved_zero;
		reg_req && !hit_evctl && !hit_fsup && !hit_fen
			|=> reg_ack && reg_rdata == 32'h0000_0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) // R10
		else $error("reserved register not zero");

	property p_fsup_value;
		s_rd(`PMFE_REG_FSUP) |=> reg_rdata == {27'h0000000, FEAT_SUPPORTED};
	endproperty
	a_fsup_value: assert property (p_fsup_value) // R12
		else $error("supported register wrong");

	property p_fen_hi_zero;
		s_rd(`PMFE_REG_FEN) |=> reg_rdata[31:4] == 28'h0000000;
	endproperty
	a_fen_hi_zero: assert property (p_fen_hi_zero) // R17
		else $error("enable register upper bits not zero");

	property p_bist_gate;
		bist_accept |-> $past(bist_fis_in && fen_reg[0]) && FEN_SUP[0];
	endproperty
	a_bist_gate: assert property (p_bist_gate) // R13
		else $error("self-test frame accepted while not allowed");

	property p_pmreq_gate;
		!fen_reg[1] |=> !pmreq_ok;
	endproperty
	a_pmreq_gate: assert property (p_pmreq_gate) // R18
		else $error("power request allowed while disabled");

	property p_notify;
		fen_reg[3] && (sum_now & ~sum_reg) != 15'h0000 |=> async_notify;
	endproperty
	a_notify: assert property (p_notify) // R15
		else $error("summary rise not notified");

	sequence s_fen_wr;
		reg_req && reg_cmd.wr && reg_cmd.num == `PMFE_REG_FEN;
	endsequence

	property p_en_reset;
		$fell(rst) |-> !cnt_enable;
	endproperty
	a_en_reset: assert property (p_en_reset) // R4
		else $error("enable not clear after reset");

	property p_fen_reset;
		$fell(rst) |-> fen_reg == FEN_RESET;
	endproperty
	a_fen_reset: assert property (p_fen_reset) // R19
		else $error("feature enables not at reset value");

	property p_pmreq_follow;
		fen_reg[`PMFE_FEAT_PMREQ] && ports_all_idle |=> pmreq_ok;
	endproperty
	a_pmreq_follow: assert property (p_pmreq_follow) // R14
		else $error("power request not allowed while idle");

	property p_fen_write;
		s_fen_wr |=>
			fen_reg == ($past(reg_cmd.wdata[NFE-1:0]) & FEN_SUP);
	endproperty
	a_fen_write: assert property (p_fen_write) // R16
		else $error("enable write landed in wrong bits");

	property p_sum_port0;
		1'b1 |=> err_summary[0] ==
			$past(|(port_error_register[0] & err_bit_enable));
	endproperty
	a_sum_port0: assert property (p_sum_port0) // R20
		else $error("port 0 error summary wrong");

	property p_busy_reads;
		s_rd(`PMFE_REG_EVCTL) ##0 clr_busy[15] |=> reg_rdata[31];
	endproperty
	a_busy_reads: assert property (p_busy_reads) // R9
		else $error("host reset bit not read as one while clearing");

	property p_en_no_clear;
		s_evctl_wr ##0 reg_cmd.wdata[31:16] == 16'h0000
			|=> cnt_clear == 16'h0000;
	endproperty
	a_en_no_clear: assert property (p_en_no_clear) // R5
		else $error("enable write cleared counters");

	property p_multi_clear;
		wr_evctl && reg_cmd.wdata[30] && reg_cmd.wdata[16]
			&& CLR_MASK[14] && !clr_busy[14] && !clr_busy[0]
			|=> cnt_clear[14] && cnt_clear[0];
	endproperty
	a_multi_clear: assert property (p_multi_clear) // R21
		else $error("reset bits written together not all serviced");

	property p_bist_block;
		!fen_reg[`PMFE_FEAT_BIST] |=> !bist_accept;
	endproperty
	a_bist_block: assert property (p_bist_block) // R13
		else $error("self-test frame accepted while disabled");

endmodule // pmfe_glb_ctrl

// [hw/pmfe_defines.svh]
// offsets, field positions, reset values for the feature/counter control
//----------------------------------------------------------------------
// Overview of operation
// R1: control register exists when counters are supported
// R2: counters on all ports; bit 0 enables
// R3: enable clear stops counting, values held
// R4: enable cleared only at power-up reset
// R5: writing enable never alters counter values
// R6: control bits 1 to 15 read zero
// R7: bit 16+n resets device port n counters
// R8: bit 31 resets host port counters
// R9: reset bits self-clear; writing zero ignored
// R10: reserved global ranges read back zero
// R11: supported register read-only, fixed per build
// R12: supported flags bits 0-4, rest zero
// R13: no self-test support refuses BIST frame
// R14: power requests allowed when all ports idle
// R15: notify host when summary bit rises
// R16: enables at same positions as support flags
// R17: enable bits 0-3, bits 31-4 zero
// R18: power request enable clear blocks requests
// R19: enable reset values follow support flags
// R20: summary bit is masked OR per port
// R21: counter resets ignore enable; all serviced
//----------------------------------------------------------------------
`ifndef PMFE_DEFINES_SVH
`define PMFE_DEFINES_SVH

// register numbers
`define PMFE_REG_EVCTL 16'h0022
`define PMFE_REG_FSUP 16'h0040
`define PMFE_REG_FEN 16'h0060

// control register fields
`define PMFE_EVCTL_EN_BIT 0
`define PMFE_EVCTL_CLR_LSB 16
`define PMFE_EVCTL_CLR_MSB 31
`define PMFE_EVCTL_RESET 32'h0000_0000

// feature flag positions, shared by supported and enabled
`define PMFE_FEAT_BIST 0
`define PMFE_FEAT_PMREQ 1
`define PMFE_FEAT_SSC 2
`define PMFE_FEAT_ASYNC 3
`define PMFE_FEAT_EVCNT 4
`define PMFE_FEN_WIDTH 4
`define PMFE_FEN_RESET_MASK 4'h5

// counter clear channels: 15 device ports plus host
`define PMFE_CLR_CHANNELS 16
`define PMFE_DEV_PORTS 15

`endif

// [hw/pmfe_pkg.sv]
// types shared by the feature/counter control block
package pmfe_pkg;

	// one register command from the host port
	typedef struct packed {
		logic wr;
		logic [15:0] num;
		logic [31:0] wdata;
	} pmfe_req_s;

	// per-channel counter clear sequence
	typedef enum logic {
		CLR_IDLE,
		CLR_BUSY
	} pmfe_clr_e;

endpackage

// [hw/pmfe_cnt_clr.sv]
// per-channel counter clear sequencer
`timescale 1ns/1ns
module pmfe_cnt_clr #(
	parameter int NCH = 16
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// requests and completions
	input wire logic [NCH-1:0] start,
	input wire logic [NCH-1:0] done,
	// clear pulse and pending state
	output logic [NCH-1:0] clr_pulse,
	output logic [NCH-1:0] busy
);

	genvar i;
	generate
		for (i = 0; i < NCH; i++) begin : g_ch
			pmfe_pkg::pmfe_clr_e state_reg, state_next;
			logic pulse_reg, pulse_next;

			// next state: a new start wins over a completion
			always_comb begin
				state_next = state_reg;
				pulse_next = 1'b0;
				case (state_reg)
					pmfe_pkg::CLR_IDLE: begin
						if (start[i]) begin
							state_next = pmfe_pkg::CLR_BUSY;
							pulse_next = 1'b1;
						end
					end
					pmfe_pkg::CLR_BUSY: begin
						if (start[i] && done[i]) begin
							pulse_next = 1'b1;
						end else if (done[i]) begin
							state_next = pmfe_pkg::CLR_IDLE;
						end
					end
					default: begin
						state_next = pmfe_pkg::CLR_IDLE;
					end
				endcase
			end

			// state registers
			always_ff @(posedge core_clk) begin
				if (rst) begin
					state_reg <= pmfe_pkg::CLR_IDLE;
					pulse_reg <= 1'b0;
				end else begin
					state_reg <= state_next;
					pulse_reg <= pulse_next;
				end
			end

			assign clr_pulse[i] = pulse_reg;
			assign busy[i] = (state_reg == pmfe_pkg::CLR_BUSY);
		end
	endgenerate

endmodule // pmfe_cnt_clr

// [tb/pmfe_cnt_model.sv]
// counter bank model answering clear requests
`timescale 1ns/1ns
module pmfe_cnt_model #(
	parameter int DLY = 3
) (
	// clock
	input wire logic core_clk,
	// count enable and clear link
	input wire logic cnt_enable,
	input wire logic [15:0] cnt_clear,
	output logic [15:0] cnt_clear_done,
	// counter values per channel
	output logic [15:0][7:0] cnt_val
);
	int left [16];

	initial begin
		cnt_clear_done = '0;
		cnt_val = '0;
		foreach (left[i]) left[i] = 0;
	end

	// clear takes DLY cycles, done pulses once at its end
	always @(posedge core_clk) begin
		for (int i = 0; i < 16; i++) begin
			cnt_clear_done[i] <= 1'b0;
			if (cnt_clear[i]) begin
				left[i] = DLY;
				cnt_val[i] <= 8'h00;
			end else if (left[i] > 0) begin
				left[i] = left[i] - 1;
				cnt_val[i] <= 8'h00;
				if (left[i] == 0) cnt_clear_done[i] <= 1'b1;
			end else if (cnt_enable) begin
				cnt_val[i] <= cnt_val[i] + 8'h01;
			end
		end
	end
endmodule // pmfe_cnt_model

// [tb/pmfe_global_status_control_regs_ctrl_test.sv]
// self-checking bench for the feature and counter control registers
`timescale 1ns/1ns
module pmfe_glb_ctrl_test;
	logic core_clk, rst, reg_req, reg_ack, cnt_enable;
	pmfe_pkg::pmfe_req_s reg_cmd;
	logic [31:0] reg_rdata, err_bit_enable, rd;
	logic [15:0] cnt_clear, cnt_clear_done;
	logic [14:0][31:0] port_error_register;
	logic [14:0] err_summary;
	logic bist_fis_in, bist_accept, ports_all_idle, pmreq_ok;
	logic ssc_enable, async_notify;
	logic [15:0][7:0] cnt_val;
	logic [7:0] v1;
	int n_errors, checks_done, cycles;

	pmfe_glb_ctrl u_dut (.core_clk, .rst, .reg_req, .reg_cmd, .reg_ack,
		.reg_rdata, .cnt_enable, .cnt_clear, .cnt_clear_done,
		.port_error_register, .err_bit_enable, .err_summary, .bist_fis_in,
		.bist_accept, .ports_all_idle, .pmreq_ok, .ssc_enable,
		.async_notify);

	pmfe_cnt_model u_cnt (.core_clk, .cnt_enable, .cnt_clear,
		.cnt_clear_done, .cnt_val);

	// 25 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// hang guard
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			complete_run;
		end
	end

	//----------------------------------------------------------------
	// helpers
	//----------------------------------------------------------------
	task automatic complete_run;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// n edges, then the drive offset
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// one register command, answer taken in the ack cycle
	task automatic acc(input logic wr, input logic [15:0] num,
		input logic [31:0] wd);
		reg_cmd = '{wr: wr, num: num, wdata: wd};
		reg_req = 1'b1;
		tick(1);
		reg_req = 1'b0;
		chk({31'h0, reg_ack}, 32'h1);
		rd = reg_rdata;
		tick(1);
		chk({31'h0, reg_ack}, 32'h0);
	endtask

	task automatic rdchk(input logic [15:0] num, input logic [31:0] exp);
		acc(1'b0, num, 32'h0);
		chk(rd, exp);
	endtask

	//----------------------------------------------------------------
	// scenarios
	//----------------------------------------------------------------
	task automatic t_reset;
		chk({31'h0, cnt_enable}, 32'h0);
		rdchk(16'h0022, 32'h0);
		rdchk(16'h0040, 32'h1f);
		rdchk(16'h0060, 32'h5);
		chk({31'h0, ssc_enable}, 32'h1);
		$display("t_reset done");
	endtask

	task automatic t_reserved;
		logic [15:0] nums [7] = '{16'h0023, 16'h003f, 16'h0041,
			16'h005f, 16'h0061, 16'h007f, 16'h0040};
		for (int i = 0; i < 7; i++) begin
			acc(1'b1, nums[i], 32'hffff_ffff);
			rdchk(nums[i], (i == 6) ? 32'h1f : 32'h0);
		end
		$display("t_reserved done");
	endtask

	task automatic t_count;
		acc(1'b1, 16'h0022, 32'h0000_ffff);
		chk({31'h0, cnt_enable}, 32'h1);
		rdchk(16'h0022, 32'h1);
		v1 = cnt_val[1];
		tick(4);
		chk({31'h0, cnt_val[1] > v1}, 32'h1);
		acc(1'b1, 16'h0022, 32'h0);
		tick(1);
		v1 = cnt_val[1];
		tick(5);
		chk({24'h0, cnt_val[1]}, {24'h0, v1});
		chk({31'h0, v1 != 8'h00}, 32'h1);
		$display("t_count done");
	endtask

	task automatic t_clear;
		acc(1'b1, 16'h0022, 32'hc001_0000);
		rdchk(16'h0022, 32'hc001_0000);
		tick(6);
		rdchk(16'h0022, 32'h0);
		chk({24'h0, cnt_val[0]}, 32'h0);
		chk({24'h0, cnt_val[14]}, 32'h0);
		chk({24'h0, cnt_val[15]}, 32'h0);
		chk({24'h0, cnt_val[1]}, {24'h0, v1});
		$display("t_clear done");
	endtask

	task automatic t_features;
		ports_all_idle = 1'b1;
		acc(1'b1, 16'h0060, 32'hffff_ffff);
		rdchk(16'h0060, 32'hf);
		chk({31'h0, pmreq_ok}, 32'h1);
		chk({31'h0, ssc_enable}, 32'h1);
		bist_fis_in = 1'b1;
		tick(1);
		chk({31'h0, bist_accept}, 32'h1);
		bist_fis_in = 1'b0;
		err_bit_enable = 32'h0000_0004;
		port_error_register[3] = 32'h0000_0004;
		tick(1);
		chk({17'h0, err_summary}, 32'h8);
		chk({31'h0, async_notify}, 32'h1);
		tick(1);
		chk({31'h0, async_notify}, 32'h0);
		port_error_register[3] = 32'h0;
		acc(1'b1, 16'h0060, 32'h0);
		tick(1);
		chk({31'h0, pmreq_ok}, 32'h0);
		chk({31'h0, ssc_enable}, 32'h0);
		bist_fis_in = 1'b1;
		tick(1);
		chk({31'h0, bist_accept}, 32'h0);
		bist_fis_in = 1'b0;
		port_error_register[3] = 32'h0000_0004;
		tick(1);
		chk({31'h0, async_notify}, 32'h0);
		port_error_register[3] = 32'h0;
		$display("t_features done");
	endtask

	// mid-run reset restores power-up values
	task automatic t_rerst;
		acc(1'b1, 16'h0022, 32'h0000_0001);
		chk({31'h0, cnt_enable}, 32'h1);
		acc(1'b1, 16'h0060, 32'h0000_0000);
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		chk({31'h0, cnt_enable}, 32'h0);
		rdchk(16'h0060, 32'h5);
		chk({31'h0, ssc_enable}, 32'h1);
		$display("t_rerst done");
	endtask

	// main sequence
	initial begin
		rst = 1'b1;
		reg_req = 1'b0;
		reg_cmd = '0;
		err_bit_enable = '0;
		port_error_register = '0;
		bist_fis_in = 1'b0;
		ports_all_idle = 1'b0;
		n_errors = 0;
		checks_done = 0;
		cycles = 0;
		tick(3);
		rst = 1'b0;
		t_reset;
		t_reserved;
		t_count;
		t_clear;
		t_features;
		t_rerst;
		complete_run;
	end
endmodule // pmfe_glb_ctrl_test
